//--- hdl/ccs_unit.sv
// Common command and status unit with APB register access
// ==========================================================
module ccs_unit
    import ccs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ops_pending,
    input wire logic err_queue_nonempty,
    input wire logic ques_event,
    input wire logic evt_query_err,
    input wire logic evt_dev_err,
    input wire logic evt_exec_err,
    input wire logic evt_cmd_err,
    output logic [31:0] setting_state,
    output logic clear_status,
    output logic irq
);
    // ==========================================================
    // State
    logic pready_ff, pslverr_ff, clear_status_ff, irq_ff;
    logic [31:0] prdata_ff, set_ff, nxt_set;
    logic [7:0] sre_ff, ese_ff, esr_ff, resp_ff;
    logic [7:0] nxt_sre, nxt_ese, nxt_esr, nxt_resp;
    logic avail_ff, opc_arm_ff, opcq_arm_ff, ques_ff, mss_prev_ff;
    logic nxt_avail, nxt_opc_arm, nxt_opcq_arm, nxt_ques;
    logic [IRQ_W-1:0] istat_ff, ien_ff, nxt_istat, nxt_ien, irq_evt;

    ccs_slot_if slot ();

    ccs_slot_store u_store (
        .clk(clk),
        .rst(rst),
        .slot(slot)
    );

    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lim);
        in_range = (v <= lim);
    endfunction : in_range

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // ==========================================================
    // APB decode
    wire acc = psel & penable & pready_ff;
    wire wr_acc = acc & pwrite;
    wire rd_acc = acc & ~pwrite;
    wire hit_cmd = hit(paddr, OFF_CMD);
    wire hit_resp = hit(paddr, OFF_RESP);
    wire hit_stb = hit(paddr, OFF_STB);
    wire hit_set = hit(paddr, OFF_SET);
    wire hit_istat = hit(paddr, OFF_IRQ_STAT);
    wire hit_iclr = hit(paddr, OFF_IRQ_CLR);
    wire hit_ien = hit(paddr, OFF_IRQ_EN);
    wire map_ok = hit_cmd | hit_resp | hit_stb | hit_set | hit_istat | hit_iclr | hit_ien;
    wire ro_bad = pwrite & (hit_resp | hit_stb | hit_istat);
    wire cmd_go = wr_acc & hit_cmd;
    wire resp_rd = rd_acc & hit_resp;
    wire ccs_op_t op = ccs_op_t'(pwdata[CMD_OP_LSB +: CMD_OP_W]);
    wire [15:0] prm = pwdata[CMD_PRM_LSB +: CMD_PRM_W];
    wire idx_ok = in_range(prm, SLOT_IDX_MAX);
    wire mask_ok = in_range(prm, MASK_MAX);

    // ==========================================================
    // Status byte
    wire esb = |(esr_ff & ese_ff);
    wire [7:0] stb_low = {2'b00, esb, avail_ff, ques_ff, err_queue_nonempty, 2'b00};
    wire master_summary_flag = |(stb_low & sre_ff);
    wire [7:0] stb = stb_low | {1'b0, master_summary_flag, 6'h00};

    // ==========================================================
    // Command decode
    wire do_sav = cmd_go & (op == OP_SAV) & idx_ok;
    wire do_rcl = cmd_go & (op == OP_RCL) & idx_ok;
    wire do_sre = cmd_go & (op == OP_SRE_W) & mask_ok;
    wire do_ese = cmd_go & (op == OP_ESE_W) & mask_ok;
    wire do_cls = cmd_go & (op == OP_CLS);
    wire do_esrq = cmd_go & (op == OP_ESR_Q);
    wire reject = cmd_go & ((((op == OP_SAV) | (op == OP_RCL)) & ~idx_ok)
        | (((op == OP_SRE_W) | (op == OP_ESE_W)) & ~mask_ok));
    wire bad_op = cmd_go & (op > OP_OPC_Q);
    wire query_now = cmd_go & ((op == OP_SRE_Q) | (op == OP_STB_Q)
        | (op == OP_ESE_Q) | (op == OP_ESR_Q));
    wire opc_done = opc_arm_ff & ~ops_pending & ~do_cls;
    wire opcq_done = opcq_arm_ff & ~ops_pending & ~query_now & ~do_cls;

    assign slot.wr_en = do_sav;
    assign slot.idx = prm[SLOT_IDX_W-1:0];
    assign slot.wdata = set_ff;

    // ==========================================================
    // Next state
    always_comb begin
        logic [7:0] evt;
        evt = 8'h00;
        evt[ESR_OPC] = opc_done;
        evt[ESR_QYE] = evt_query_err | (resp_rd & ~avail_ff);
        evt[ESR_DDE] = evt_dev_err;
        evt[ESR_EXE] = evt_exec_err | reject;
        evt[ESR_CME] = evt_cmd_err | bad_op;
        nxt_set = set_ff;
        nxt_sre = sre_ff;
        nxt_ese = ese_ff;
        nxt_resp = resp_ff;
        nxt_avail = avail_ff & ~resp_rd;
        nxt_opc_arm = opc_arm_ff & ~opc_done;
        nxt_opcq_arm = opcq_arm_ff & ~opcq_done;
        nxt_ques = ques_ff | ques_event;
        if (wr_acc & hit_set) begin
            nxt_set = pwdata;
        end
        if (cmd_go) begin
            case (op)
                OP_RST: nxt_set = SET_FACTORY;
                OP_RCL: if (idx_ok) nxt_set = slot.rdata;
                OP_SRE_W: if (mask_ok) nxt_sre = prm[7:0];
                OP_ESE_W: if (mask_ok) nxt_ese = prm[7:0];
                OP_OPC: nxt_opc_arm = 1'b1;
                OP_OPC_Q: nxt_opcq_arm = 1'b1;
                default: nxt_set = nxt_set;
            endcase
        end
        if (query_now) begin
            case (op)
                OP_SRE_Q: nxt_resp = sre_ff;
                OP_STB_Q: nxt_resp = stb;
                OP_ESE_Q: nxt_resp = ese_ff;
                default: nxt_resp = esr_ff;
            endcase
            nxt_avail = 1'b1;
        end else if (opcq_done) begin
            nxt_resp = 8'h01;
            nxt_avail = 1'b1;
        end
        if (do_cls) begin
            nxt_avail = 1'b0;
            nxt_ques = ques_event;
            nxt_opc_arm = 1'b0;
            nxt_opcq_arm = 1'b0;
        end
        nxt_esr = ((do_cls | do_esrq) ? 8'h00 : esr_ff) | evt;
    end

    // ==========================================================
    // Interrupts
    assign irq_evt = {master_summary_flag & ~mss_prev_ff, opc_done, reject, cmd_go};
    assign nxt_istat = (istat_ff & ~((wr_acc & hit_iclr) ? pwdata[IRQ_W-1:0] : '0)) | irq_evt;
    assign nxt_ien = (wr_acc & hit_ien) ? pwdata[IRQ_W-1:0] : ien_ff;

    wire [31:0] rd_word = hit_resp ? {23'h0, avail_ff, resp_ff}
        : hit_stb ? {24'h0, stb}
        : hit_set ? set_ff
        : hit_istat ? {28'h0, istat_ff}
        : hit_ien ? {28'h0, ien_ff}
        : 32'h0;

    // ==========================================================
    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= psel & ~penable;
            pslverr_ff <= psel & ~penable & (~map_ok | ro_bad);
            prdata_ff <= (psel & ~penable & ~pwrite) ? rd_word : 32'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            set_ff <= SET_FACTORY;
            sre_ff <= MASK_RESET;
            ese_ff <= MASK_RESET;
            esr_ff <= ESR_RESET;
            resp_ff <= 8'h00;
            avail_ff <= 1'b0;
            opc_arm_ff <= 1'b0;
            opcq_arm_ff <= 1'b0;
            ques_ff <= 1'b0;
        end else begin
            set_ff <= nxt_set;
            sre_ff <= nxt_sre;
            ese_ff <= nxt_ese;
            esr_ff <= nxt_esr;
            resp_ff <= nxt_resp;
            avail_ff <= nxt_avail;
            opc_arm_ff <= nxt_opc_arm;
            opcq_arm_ff <= nxt_opcq_arm;
            ques_ff <= nxt_ques;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            istat_ff <= '0;
            ien_ff <= '0;
            irq_ff <= 1'b0;
            mss_prev_ff <= 1'b0;
            clear_status_ff <= 1'b0;
        end else begin
            istat_ff <= nxt_istat;
            ien_ff <= nxt_ien;
            irq_ff <= |(nxt_istat & nxt_ien);
            mss_prev_ff <= master_summary_flag;
            clear_status_ff <= do_cls;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign setting_state = set_ff;
    assign clear_status = clear_status_ff;
    assign irq = irq_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_cmd(ccs_op_t c);
        cmd_go && op == c;
    endsequence
    sequence s_reject;
        reject && !evt_exec_err;
    endsequence
    sequence s_kept;
        sre_ff == $past(sre_ff) && ese_ff == $past(ese_ff) && set_ff == $past(set_ff);
    endsequence

    property p_sav;
        (s_cmd(OP_SAV) and idx_ok) |-> slot.wr_en && slot.wdata == set_ff;
    endproperty
    a_sav: assert property (p_sav) else $error("save did not write slot");
    property p_rcl;
        (s_cmd(OP_RCL) and idx_ok) |=> set_ff == $past(slot.rdata);
    endproperty
    a_rcl: assert property (p_rcl) else $error("recall did not restore");
    property p_rst;
        s_cmd(OP_RST) |=> set_ff == SET_FACTORY
            && (esr_ff[7:1] & $past(esr_ff[7:1])) == $past(esr_ff[7:1]);
    endproperty
    a_rst: assert property (p_rst) else $error("reset wrong");
    property p_sre;
        (s_cmd(OP_SRE_W) and mask_ok) |=> sre_ff == $past(prm[7:0]);
    endproperty
    a_sre: assert property (p_sre) else $error("service mask not loaded");
    property p_sreq;
        s_cmd(OP_SRE_Q) |=> avail_ff && resp_ff == $past(sre_ff) && sre_ff == $past(sre_ff);
    endproperty
    a_sreq: assert property (p_sreq) else $error("service mask query wrong");
    property p_stbq;
        s_cmd(OP_STB_Q) |=> resp_ff == $past(stb) && sre_ff == $past(sre_ff);
    endproperty
    a_stbq: assert property (p_stbq) else $error("status byte query wrong");
    property p_ese;
        (s_cmd(OP_ESE_W) and mask_ok) |=> ese_ff == $past(prm[7:0]);
    endproperty
    a_ese: assert property (p_ese) else $error("event mask not stored");
    property p_esrq;
        s_cmd(OP_ESR_Q) && !evt_dev_err && !evt_query_err |=> resp_ff == $past(esr_ff)
            && esr_ff[7:6] == 2'b00;
    endproperty
    a_esrq: assert property (p_esrq) else $error("event query not cleared");
    property p_cls;
        s_cmd(OP_CLS) |=> (!avail_ff && clear_status && esr_ff[ESR_OPC] == 1'b0) and s_kept;
    endproperty
    a_cls: assert property (p_cls) else $error("clear status wrong");
    property p_opc;
        opc_arm_ff && !ops_pending && !do_cls && !(cmd_go && op == OP_OPC)
            |=> esr_ff[ESR_OPC] && !opc_arm_ff;
    endproperty
    a_opc: assert property (p_opc) else $error("completion bit missing");
    property p_opcq;
        opcq_arm_ff && ops_pending |=> resp_ff == $past(resp_ff) || $past(cmd_go);
    endproperty
    a_opcq: assert property (p_opcq) else $error("early completion answer");
    property p_rej;
        s_reject |=> esr_ff[ESR_EXE] and s_kept;
    endproperty
    a_rej: assert property (p_rej) else $error("bad parameter not rejected");
endmodule : ccs_unit

//--- hdl/ccs_pkg.sv
// Constants, register map and command codes of the common command status unit
package ccs_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_RESP = 8'h04;
    localparam logic [7:0] OFF_STB = 8'h08;
    localparam logic [7:0] OFF_SET = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h14;
    localparam logic [7:0] OFF_IRQ_EN = 8'h18;
    // ==========================================================
    // Command word fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_OP_W = 4;
    localparam int CMD_PRM_LSB = 8;
    localparam int CMD_PRM_W = 16;
    localparam int RESP_AVAIL_BIT = 8;
    // ==========================================================
    // Ranges, slots and reset values
    localparam int SLOT_NUM = 10;
    localparam int SLOT_IDX_W = 4;
    localparam logic [15:0] SLOT_IDX_MAX = 16'h0009;
    localparam logic [15:0] MASK_MAX = 16'h00ff;
    localparam logic [31:0] SET_FACTORY = 32'h0000_0000;
    localparam logic [7:0] ESR_RESET = 8'h80;
    localparam logic [7:0] MASK_RESET = 8'h00;
    // ==========================================================
    // Standard event and status byte bit positions
    localparam int ESR_OPC = 0;
    localparam int ESR_QYE = 2;
    localparam int ESR_DDE = 3;
    localparam int ESR_EXE = 4;
    localparam int ESR_CME = 5;
    localparam int STB_ERRQ = 2;
    localparam int STB_QUES = 3;
    localparam int STB_MAV = 4;
    localparam int STB_ESB = 5;
    localparam int STB_MSS = 6;
    // ==========================================================
    // Interrupt bits
    localparam int IRQ_W = 4;
    localparam int IRQ_CMD = 0;
    localparam int IRQ_REJ = 1;
    localparam int IRQ_OPC = 2;
    localparam int IRQ_SRQ = 3;
    // ==========================================================
    // Command codes
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_RST = 4'h1,
        OP_SAV = 4'h2,
        OP_RCL = 4'h3,
        OP_SRE_W = 4'h4,
        OP_SRE_Q = 4'h5,
        OP_STB_Q = 4'h6,
        OP_ESE_W = 4'h7,
        OP_ESE_Q = 4'h8,
        OP_ESR_Q = 4'h9,
        OP_CLS = 4'ha,
        OP_OPC = 4'hb,
        OP_OPC_Q = 4'hc
    } ccs_op_t;
endpackage : ccs_pkg

//--- hdl/ccs_slot_if.sv
// Link between the command unit and its setup slot store
interface ccs_slot_if;
    logic wr_en;
    logic [3:0] idx;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport store (input wr_en, input idx, input wdata, output rdata);
    modport user (output wr_en, output idx, output wdata, input rdata);
endinterface : ccs_slot_if

//--- hdl/ccs_slot_store.sv
// Ten numbered setup slots holding saved setting states
module ccs_slot_store
    import ccs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    ccs_slot_if.store slot
);
    logic [31:0] mem_ff [SLOT_NUM];

    // ==========================================================
    // Slot array
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < SLOT_NUM; i++) begin
                mem_ff[i] <= SET_FACTORY;
            end
        end else if (slot.wr_en) begin
            mem_ff[slot.idx] <= slot.wdata;
        end
    end

    assign slot.rdata = mem_ff[slot.idx];
endmodule : ccs_slot_store

//--- tb/ccs_host_model.sv
// APB master standing in for the remote host
module ccs_host_model (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Idle bus
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // ==========================================================
    // One transfer, entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge clk);
    endtask : xfer
endmodule : ccs_host_model

//--- tb/ccs_unit_tb_top.sv
// Self-checking bench of the common command status unit
module ccs_unit_tb_top
    import ccs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [3:0] op;
        logic [15:0] prm;
        logic [3:0] qop;
        logic [31:0] exp;
    } ccs_row_t;
    logic clk;
    logic rst;
    logic ops = 1'b0;
    logic erq = 1'b0;
    logic [4:0] ev = 5'h00;
    wire logic psel, penable, pwrite, pready, pslverr;
    wire logic [7:0] paddr;
    wire logic [31:0] pwdata, prdata;
    logic [31:0] setting_state;
    logic clear_status;
    logic irq;
    int n_fail = 0;
    int comparisons = 0;
    int n_cls = 0;
    int cyc = 0;
    ccs_row_t rows [10] = '{
        '{OP_SRE_W, 16'h00ff, OP_SRE_Q, 32'h1ff},
        '{OP_ESE_W, 16'h0041, OP_ESE_Q, 32'h141},
        '{OP_NOP, 16'h0, OP_ESR_Q, 32'h184},
        '{OP_NOP, 16'h0, OP_ESR_Q, 32'h100},
        '{OP_SRE_W, 16'h0100, OP_SRE_Q, 32'h1ff},
        '{OP_NOP, 16'h0, OP_ESR_Q, 32'h110},
        '{OP_SAV, 16'h000a, OP_ESR_Q, 32'h110},
        '{OP_RCL, 16'h000a, OP_ESR_Q, 32'h110},
        '{OP_ESE_W, 16'h0100, OP_ESE_Q, 32'h141},
        '{4'hd, 16'h0, OP_ESR_Q, 32'h130}};
    // ==========================================================
    // Design and host
    ccs_unit u_ccs_unit (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ops_pending(ops),
        .err_queue_nonempty(erq), .ques_event(ev[0]), .evt_query_err(ev[1]),
        .evt_dev_err(ev[2]), .evt_exec_err(ev[3]), .evt_cmd_err(ev[4]),
        .setting_state(setting_state), .clear_status(clear_status), .irq(irq));
    ccs_host_model u_ccs_host_model (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    // ==========================================================
    // Clock, timeout, pulse count
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (clear_status === 1'b1) n_cls <= n_cls + 1;
        if (cyc == 6000) begin
            n_fail++;
            summarize();
        end
    end
    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] ed, input logic ee);
        logic [31:0] rd;
        logic er;
        u_ccs_host_model.xfer(w, a, d, rd, er);
        chk(rd, ed);
        chk({31'h0, er}, {31'h0, ee});
    endtask : acc
    task automatic cmd(input logic [3:0] o, input logic [15:0] p);
        acc(1'b1, OFF_CMD, {8'h00, p, 4'h0, o}, 32'h0, 1'b0);
    endtask : cmd
    task automatic q(input logic [3:0] o, input logic [31:0] e);
        cmd(o, 16'h0);
        acc(1'b0, OFF_RESP, 32'h0, e, 1'b0);
    endtask : q
    task automatic pulse(input logic [4:0] m);
        ev <= m;
        @(posedge clk);
        ev <= 5'h00;
        @(posedge clk);
    endtask : pulse
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    // ==========================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(setting_state, 32'h0);
        chk({31'h0, irq}, 32'h0);
        acc(1'b0, OFF_SET, 32'h0, 32'h0, 1'b0);
        acc(1'b0, OFF_STB, 32'h0, 32'h0, 1'b0);
        acc(1'b0, OFF_RESP, 32'h0, 32'h0, 1'b0);
        acc(1'b0, 8'h1c, 32'h0, 32'h0, 1'b1);
        acc(1'b0, 8'h02, 32'h0, 32'h0, 1'b1);
        acc(1'b1, OFF_STB, 32'h5, 32'h0, 1'b1);
        acc(1'b1, OFF_IRQ_STAT, 32'h1, 32'h0, 1'b1);
        for (int i = 0; i < 10; i++) begin
            cmd(rows[i].op, rows[i].prm);
            q(rows[i].qop, rows[i].exp);
        end
        acc(1'b1, OFF_IRQ_CLR, 32'hf, 32'h0, 1'b0);
        acc(1'b0, OFF_IRQ_STAT, 32'h0, 32'h0, 1'b0);
        cmd(OP_ESE_W, 16'h0041);
        acc(1'b0, OFF_IRQ_STAT, 32'h0, 32'h1, 1'b0);
        chk({31'h0, irq}, 32'h0);
        acc(1'b1, OFF_IRQ_EN, 32'h1, 32'h0, 1'b0);
        @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        acc(1'b0, OFF_IRQ_EN, 32'h0, 32'h1, 1'b0);
        acc(1'b1, OFF_IRQ_CLR, 32'h1, 32'h0, 1'b0);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        acc(1'b1, OFF_IRQ_EN, 32'h0, 32'h0, 1'b0);
        erq <= 1'b1;
        @(posedge clk);
        acc(1'b0, OFF_STB, 32'h0, 32'h44, 1'b0);
        cmd(OP_STB_Q, 16'h0);
        acc(1'b0, OFF_STB, 32'h0, 32'h54, 1'b0);
        acc(1'b0, OFF_RESP, 32'h0, 32'h144, 1'b0);
        acc(1'b0, OFF_STB, 32'h0, 32'h44, 1'b0);
        cmd(OP_SRE_W, 16'h0008);
        acc(1'b0, OFF_STB, 32'h0, 32'h04, 1'b0);
        cmd(OP_SRE_W, 16'h00ff);
        erq <= 1'b0;
        ops <= 1'b1;
        cmd(OP_OPC, 16'h0);
        repeat (4) @(posedge clk);
        acc(1'b0, OFF_STB, 32'h0, 32'h00, 1'b0);
        ops <= 1'b0;
        repeat (3) @(posedge clk);
        acc(1'b0, OFF_STB, 32'h0, 32'h60, 1'b0);
        q(OP_ESR_Q, 32'h101);
        ops <= 1'b1;
        cmd(OP_OPC_Q, 16'h0);
        repeat (4) @(posedge clk);
        acc(1'b0, OFF_STB, 32'h0, 32'h00, 1'b0);
        ops <= 1'b0;
        repeat (3) @(posedge clk);
        acc(1'b0, OFF_STB, 32'h0, 32'h50, 1'b0);
        acc(1'b0, OFF_RESP, 32'h0, 32'h101, 1'b0);
        pulse(5'h01);
        acc(1'b0, OFF_STB, 32'h0, 32'h48, 1'b0);
        cmd(OP_CLS, 16'h0);
        acc(1'b0, OFF_STB, 32'h0, 32'h00, 1'b0);
        chk(32'(n_cls), 32'h1);
        q(OP_ESR_Q, 32'h100);
        q(OP_ESE_Q, 32'h141);
        q(OP_SRE_Q, 32'h1ff);
        pulse(5'h1e);
        cmd(OP_RST, 16'h0);
        q(OP_ESR_Q, 32'h13c);
        for (int i = 0; i < 10; i++) begin
            acc(1'b1, OFF_SET, {8{4'(i)}}, 32'h0, 1'b0);
            cmd(OP_SAV, 16'(i));
        end
        acc(1'b1, OFF_SET, 32'hffff_ffff, 32'h0, 1'b0);
        cmd(OP_RST, 16'h0);
        acc(1'b0, OFF_SET, 32'h0, 32'h0, 1'b0);
        chk(setting_state, 32'h0);
        for (int i = 0; i < 10; i++) begin
            cmd(OP_RCL, 16'(i));
            acc(1'b0, OFF_SET, 32'h0, {8{4'(i)}}, 1'b0);
            chk(setting_state, {8{4'(i)}});
        end
        cmd(OP_RCL, 16'h000a);
        acc(1'b0, OFF_SET, 32'h0, 32'h9999_9999, 1'b0);
        acc(1'b0, OFF_IRQ_STAT, 32'h0, 32'hf, 1'b0);
        summarize();
    end
endmodule : ccs_unit_tb_top
